// ### hw/scf_fifo.sv
/*
 * single-clock fifo with wishbone control, show-ahead option and a
 * software push path through a staging buffer.
 * assumes producer and consumer logic on mclk_i and a classic
 * wishbone master on the same clock.
 */
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ns
`default_nettype none
module scf_fifo
    import scf_pkg::*;
#(
    parameter int         DEPTH      = scf_pkg::SCF_DEPTH_DEF,
    parameter int         INT_BITS   = scf_pkg::SCF_INT_DEF,
    parameter int         FRAC_BITS  = scf_pkg::SCF_FRAC_DEF,
    parameter scf_pkg::scf_dtype_t DTYPE = scf_pkg::SCF_SIGNED_INT,
    parameter bit         USE_SCLR   = 1'b1,
    parameter bit         SHOW_AHEAD = 1'b0,
    localparam int        DW = scf_pkg::scf_width(DTYPE, INT_BITS, FRAC_BITS),
    localparam int        UW = $clog2(DEPTH+1)
) (
    input  wire logic           mclk_i,   // 125 MHz clock
    input  wire logic           rst_n_i,  // sync reset, low
    // datapath side
    input  wire logic [DW-1:0]  d_i,      // word to store
    input  wire logic           wrreq_i,  // write request
    input  wire logic           rdreq_i,  // read request
    input  wire logic           sclr_i,   // synchronous clear
    output logic      [DW-1:0]  q_o,      // word read out
    output logic                q_sign_o, // sign of q_o
    output logic                full_o,   // no room left
    output logic                empty_o,  // nothing stored
    output logic      [UW-1:0]  usedw_o,  // words held
    output logic                wr_ready_o, // write would be taken
    // wishbone slave
    input  wire logic           wb_cyc_i, // bus cycle
    input  wire logic           wb_stb_i, // strobe
    input  wire logic           wb_we_i,  // write enable
    input  wire logic [3:0]     wb_adr_i, // byte address
    input  wire logic [3:0]     wb_sel_i, // byte lanes
    input  wire logic [31:0]    wb_dat_i, // write data
    output logic      [31:0]    wb_dat_o, // read data
    output logic                wb_ack_o  // acknowledge
);
    import scf_pkg::*;

    // ------------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------------
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int SW = $clog2(SCF_STAGE_DEPTH+1);

    // one clock for writer, reader and bus
    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [UW-1:0] count;
    logic          show;
    logic          sclr_en;
    logic          flush;

    logic          wr_go;
    logic          rd_go;
    logic          clr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] next_rptr;
    logic [AW-1:0] next_wptr;
    logic [UW-1:0] next_count;
    logic [DW-1:0] next_head;

    logic          st_in_valid;
    logic          st_in_ready;
    logic          st_valid;
    logic          st_ready;
    logic [DW-1:0] st_data;
    logic [SW-1:0] st_count;

    logic          req;
    logic          push_req;
    logic [31:0]   rd_word;

    // wrap for any depth, not only powers of two
    function automatic logic [AW-1:0] step(logic [AW-1:0] p);
        return (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
    endfunction

    // ------------------------------------------------------------------
    // flags and accepted operations
    // ------------------------------------------------------------------
    // full and empty single bits, count its own unsigned width
    assign full_o  = (count == UW'(DEPTH));
    assign empty_o = (count == '0);
    assign usedw_o = count;

    // clear on the input only when the option is built in and enabled, or on a software flush
    assign clr = (USE_SCLR && sclr_en && sclr_i) || flush;

    // datapath writes win; the staging buffer drains in idle slots
    assign wr_go      = (wrreq_i || st_valid) && !full_o;
    assign wr_data    = wrreq_i ? d_i : st_data;
    assign st_ready   = !wrreq_i && !full_o;
    assign wr_ready_o = !full_o;

    // a read on an empty buffer moves nothing
    assign rd_go = rdreq_i && !empty_o;

    assign next_wptr = wr_go ? step(wptr) : wptr;
    assign next_rptr = rd_go ? step(rptr) : rptr;

    // simultaneous write and read leave the count alone
    always_comb
    begin
        next_count = count;
        if (wr_go && !rd_go)
            next_count = UW'(count + 1'b1);
        else if (rd_go && !wr_go)
            next_count = UW'(count - 1'b1);
    end

    // head after this edge; a word landing on it bypasses the array
    assign next_head = (wr_go && wptr == next_rptr) ? wr_data
                                                    : mem[next_rptr];

    // ------------------------------------------------------------------
    // array, pointers, count
    // ------------------------------------------------------------------
    // writes land even during clear; pointers reset makes them dead
    always_ff @(posedge mclk_i)
    begin
        if (wr_go)
            mem[wptr] <= wr_data;
    end

    // clear outranks every request
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i || clr)
        begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end
        else
        begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            count <= next_count;
        end
    end

    // ------------------------------------------------------------------
    // output word
    // ------------------------------------------------------------------
    // show-ahead keeps q on the head; normal mode loads it on a read.
    // q holds its last value when the buffer runs dry
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            q_o <= '0;
        else if (clr)
            q_o <= q_o;
        else if (show)
        begin
            if (next_count != '0)
                q_o <= next_head;
        end
        else if (rd_go)
            q_o <= mem[rptr];
    end

    // only signed formats have a sign bit
    assign q_sign_o = (DTYPE != SCF_UNSIGNED_INT) ? q_o[DW-1] : 1'b0;

    // ------------------------------------------------------------------
    // software push path
    // ------------------------------------------------------------------
    // a full stage stalls the bus ack, so software feels back-pressure
    scf_stage #(
        .WIDTH (DW),
        .DEPTH (SCF_STAGE_DEPTH)
    ) u_stage (
        .mclk_i        (mclk_i),
        .rst_n_i       (rst_n_i),
        .in_valid_i    (st_in_valid),
        .in_ready_o    (st_in_ready),
        .in_data_i     (DW'(wb_dat_i)),
        .out_valid_o   (st_valid),
        .out_ready_o_i (st_ready),
        .out_data_o    (st_data),
        .count_o       (st_count)
    );

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign push_req = req && wb_we_i && wb_adr_i == SCF_ADR_PUSH;
    assign st_in_valid = push_req && wb_sel_i[0];

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rd_word = 32'h0;
        unique case (wb_adr_i)
            SCF_ADR_CTRL:
            begin
                rd_word[SCF_CTRL_SHOW] = show;
                rd_word[SCF_CTRL_SCLR] = sclr_en;
            end
            SCF_ADR_STATUS:
            begin
                rd_word[SCF_ST_EMPTY]  = empty_o;
                rd_word[SCF_ST_FULL]   = full_o;
                rd_word[SCF_ST_STFULL] = !st_in_ready;
                rd_word[SCF_ST_STEMP]  = !st_valid;
                rd_word[SCF_ST_USEDW +: UW] = count;
                rd_word[SCF_ST_STCNT +: SW] = st_count;
            end
            SCF_ADR_PUSH:
                rd_word = 32'(q_o);
            SCF_ADR_CONFIG:
            begin
                rd_word[SCF_CFG_WIDTH +: 8] = 8'(DW);
                rd_word[SCF_CFG_DEPTH +: 16] = 16'(DEPTH);
                rd_word[SCF_CFG_DTYPE +: 2] = DTYPE;
            end
            default:
                rd_word = 32'h0;
        endcase
    end

    // one-cycle answer; a push waits for a free stage slot
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req && (!push_req || st_in_ready || !wb_sel_i[0]);
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            wb_dat_o <= 32'h0;
        else if (req && !wb_we_i)
            wb_dat_o <= rd_word;
    end

    // ctrl register; flush is a one-cycle pulse and reads zero
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            show    <= SHOW_AHEAD;
            sclr_en <= SCF_SCLR_RST;
            flush   <= 1'b0;
        end
        else
        begin
            flush <= 1'b0;
            if (req && wb_we_i && wb_adr_i == SCF_ADR_CTRL && wb_sel_i[0])
            begin
                show    <= wb_dat_i[SCF_CTRL_SHOW];
                sclr_en <= wb_dat_i[SCF_CTRL_SCLR];
                flush   <= wb_dat_i[SCF_CTRL_FLUSH];
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    count_track_a: assert property (
        rst_n_i && !clr |=> count == UW'($past(count) + UW'($past(wr_go))
                              - UW'($past(rd_go))))
        else $error("word count off after an operation");
    full_block_a: assert property (
        full_o && !rdreq_i && !clr |=> full_o && $stable(wptr))
        else $error("write taken while full");
    empty_block_a: assert property (
        empty_o && !wrreq_i && !st_valid && !clr
        |=> empty_o && $stable(rptr))
        else $error("read moved an empty buffer");
    clear_state_a: assert property (
        clr |=> usedw_o == '0 && empty_o && !full_o)
        else $error("clear left words behind");
    store_word_a: assert property (
        wr_go && !clr |=> mem[$past(wptr)] == $past(wr_data))
        else $error("written word not stored");
    normal_read_a: assert property (
        rd_go && !show && !clr |=> q_o == $past(mem[rptr]))
        else $error("read did not return oldest word");
    show_head_a: assert property (
        show && $past(show) && !empty_o && !$past(clr) |-> q_o == mem[rptr])
        else $error("show-ahead head not visible");
    sign_bit_a: assert property (
        DTYPE != SCF_UNSIGNED_INT |-> q_sign_o == q_o[DW-1])
        else $error("sign bit not the top bit");
    bus_ack_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

endmodule
`default_nettype wire

// ### hw/scf_pkg.sv
/*
 * constants, types and the register map of the single-clock fifo.
 * assumes one clock and one synchronous active-low reset around it.
 */
// Function
// - one clock serves writer and reader; depth and format fixed at build
// - write request on an edge stores the input word
// - read request removes oldest word onto output, strict fifo order
// - enabled synchronous clear discards every word, buffer becomes empty
// - full shown when no room left; writes ignored while full
// - empty shown when nothing stored; reads ignored while empty
// - word count always equals words held
// - depth is a parameter, default sixty-four words
// - option selects show-ahead: head word visible before its read
// - width is integer bits plus fraction bits; in and out equal
// - fraction bits only count for signed fractional data
// - signed formats treat the top bit as sign
// - word count has its own unsigned width; full and empty single bits
package scf_pkg;

    // ------------------------------------------------------------------
    // data formats
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCF_SIGNED_INT,
        SCF_SIGNED_FRAC,
        SCF_UNSIGNED_INT
    } scf_dtype_t;

    localparam int SCF_DEPTH_DEF   = 64;
    localparam int SCF_INT_DEF     = 16;
    localparam int SCF_FRAC_DEF    = 0;
    localparam int SCF_STAGE_DEPTH = 8;

    // fraction bits vanish for integer formats
    function automatic int scf_width(scf_dtype_t t, int l, int r);
        return (t == SCF_SIGNED_FRAC) ? l + r : l;
    endfunction

    // ------------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [3:0] SCF_ADR_CTRL   = 4'h0;
    localparam logic [3:0] SCF_ADR_STATUS = 4'h4;
    localparam logic [3:0] SCF_ADR_PUSH   = 4'h8;
    localparam logic [3:0] SCF_ADR_CONFIG = 4'hc;

    // ctrl fields
    localparam int SCF_CTRL_SHOW  = 0;
    localparam int SCF_CTRL_SCLR  = 1;
    localparam int SCF_CTRL_FLUSH = 2;
    localparam logic SCF_SCLR_RST = 1'b1;

    // status fields
    localparam int SCF_ST_EMPTY  = 0;
    localparam int SCF_ST_FULL   = 1;
    localparam int SCF_ST_STFULL = 2;
    localparam int SCF_ST_STEMP  = 3;
    localparam int SCF_ST_USEDW  = 8;
    localparam int SCF_ST_STCNT  = 24;

    // config fields
    localparam int SCF_CFG_WIDTH = 0;
    localparam int SCF_CFG_DEPTH = 8;
    localparam int SCF_CFG_DTYPE = 24;

endpackage

// ### hw/scf_stage.sv
/*
 * small staging fifo with valid/ready on both sides.
 * assumes same clock on both sides and a synchronous active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module scf_stage #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic                       mclk_i,    // system clock
    input  wire logic                       rst_n_i,   // sync reset, low
    input  wire logic                       in_valid_i,// word offered
    output logic                            in_ready_o,// room left
    input  wire logic [WIDTH-1:0]           in_data_i, // offered word
    output logic                            out_valid_o,// word held
    input  wire logic                       out_ready_o_i,// drain taken
    output logic [WIDTH-1:0]                out_data_o,// oldest word
    output logic [$clog2(DEPTH+1)-1:0]      count_o    // words held
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] step(logic [AW-1:0] p);
        return (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
    endfunction

    // honest flags: ready only with a free slot, valid only with a word
    assign in_ready_o  = (count != CW'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_o_i;
    assign out_data_o  = mem[rptr];
    assign count_o     = count;

    // storage carries no reset, only valid words are ever read
    always_ff @(posedge mclk_i)
    begin
        if (push)
            mem[wptr] <= in_data_i;
    end

    // pointers and fill level
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wptr <= step(wptr);
            if (pop)
                rptr <= step(rptr);
            count <= CW'(count + CW'(push) - CW'(pop));
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    stage_bound_a: assert property (count <= CW'(DEPTH))
        else $error("stage fill above depth");
    stage_hold_a: assert property (!in_ready_o && !pop |=> !in_ready_o)
        else $error("stage full flag dropped without a drain");

endmodule
`default_nettype wire

// ### test/scf_dp_model.sv
/*
 * datapath partner: producer and consumer logic around the fifo.
 * assumes the bench calls step once per clock cycle it wants to drive.
 */
`timescale 1ns/1ns
`default_nettype none
module scf_dp_model #(
    parameter int DW = 16
) (
    input  wire logic          mclk_i, // system clock
    output logic [DW-1:0]      d_o,    // word offered
    output logic               wr_o,   // write request
    output logic               rd_o,   // read request
    output logic               clr_o   // synchronous clear
);
    // ------------------------------------------------------------------
    // request driver
    // ------------------------------------------------------------------
    // idle at time zero so nothing is asked before reset lets go
    initial
    begin
        d_o   = '0;
        wr_o  = 1'b0;
        rd_o  = 1'b0;
        clr_o = 1'b0;
    end

    // one cycle of requests, launched just after an edge and held
    task automatic step(input logic w, input logic r, input logic c,
                        input logic [DW-1:0] d);
        @(posedge mclk_i);
        wr_o  <= w;
        rd_o  <= r;
        clr_o <= c;
        // an idle data line never repeats the last word
        d_o   <= w ? d : ~d_o;
    endtask
endmodule
`default_nettype wire

// ### test/test_scf_fifo.sv
/*
 * self-checking bench for the single-clock fifo: datapath through the
 * partner model, control and push path over classic wishbone.
 * assumes the fifo and staging modules from hw/ and scf_pkg compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module test_scf_fifo;
    import scf_pkg::*;
    localparam int DEP = 8;
    localparam int DW  = 16;
    logic           mclk_i = 1'b0;
    logic           rst_n_i = 1'b0;
    logic           wb_cyc_i = 1'b0;
    logic           wb_stb_i = 1'b0;
    logic           wb_we_i = 1'b0;
    logic [3:0]     wb_adr_i = 4'h0;
    logic [3:0]     wb_sel_i = 4'hf;
    logic [31:0]    wb_dat_i = 32'h0;
    wire  [31:0]    wb_dat_o;
    wire            wb_ack_o, wr, rd, clr, q_sign_o, full_o, empty_o, wrdy;
    wire  [DW-1:0]  d, q_o;
    wire  [3:0]     usedw_o;
    logic [31:0]    r;
    logic [DW-1:0]  exp_q[$];
    int             err_count = 0;
    int             n_checks = 0;
    int             cyc_n = 0;

    scf_fifo #(.DEPTH(DEP)) u_scf_fifo (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .d_i(d), .wrreq_i(wr), .rdreq_i(rd), .sclr_i(clr), .q_o(q_o),
        .q_sign_o(q_sign_o), .full_o(full_o), .empty_o(empty_o),
        .usedw_o(usedw_o), .wr_ready_o(wrdy), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o));
    scf_dp_model #(.DW(DW)) u_scf_dp_model (.mclk_i(mclk_i), .d_o(d),
        .wr_o(wr), .rd_o(rd), .clr_o(clr));

    // ------------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------------
    always #4 mclk_i = ~mclk_i;

    // whole run is under two hundred cycles; the ceiling of 20000 leaves ample margin
    always @(posedge mclk_i)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // status flags all follow from the expected fill level
    task automatic flags(input int n);
        chk(32'(usedw_o), n, "count");
        chk(32'(empty_o), 32'(n == 0), "empty");
        chk(32'(full_o), 32'(n == DEP), "full");
        chk(32'(wrdy), 32'(n != DEP), "ready");
    endtask

    // classic single cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] dd);
        int n;
        n = 0;
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= dd;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 100);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 100)
            chk(32'h0, 32'h1, "no ack");
    endtask

    // read, then two idle cycles so a stalled stage can refill the fifo
    task automatic pop(input logic c);
        u_scf_dp_model.step(1'b0, 1'b1, 1'b0, '0);
        u_scf_dp_model.step(1'b0, 1'b0, 1'b0, '0);
        u_scf_dp_model.step(1'b0, 1'b0, 1'b0, '0);
        #1;
        if (c)
        begin
            chk(32'(q_o), 32'(exp_q[0]), "order");
            chk(32'(q_sign_o), 32'(exp_q[0][DW-1]), "sign");
            void'(exp_q.pop_front());
        end
    endtask

    task automatic idle;
        u_scf_dp_model.step(1'b0, 1'b0, 1'b0, '0);
        #1;
    endtask

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        idle();
        flags(0);
        wb(1'b0, SCF_ADR_CONFIG, 32'h0);
        chk(r, {6'h0, SCF_SIGNED_INT, 16'(DEP), 8'(DW)}, "config");
        wb(1'b0, 4'h2, 32'h0);
        chk(r, 32'h0, "unmapped");
        // back-to-back fill, sign bit alternating
        for (int i = 0; i < DEP; i++)
        begin
            u_scf_dp_model.step(1'b1, 1'b0, 1'b0, {i[0], 11'h0, i[3:0]});
            exp_q.push_back({i[0], 11'h0, i[3:0]});
        end
        idle();
        flags(DEP);
        u_scf_dp_model.step(1'b1, 1'b0, 1'b0, 16'h7777);
        idle();
        flags(DEP);
        // stage fills behind a full fifo and must not overtake it
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b1, SCF_ADR_PUSH, 32'h100 + i);
            exp_q.push_back(16'h100 + 16'(i));
        end
        wb(1'b0, SCF_ADR_STATUS, 32'h0);
        chk(r, 32'h0800_0806, "stage full");
        // a ninth push stalls until a read lets the stage drain
        exp_q.push_back(16'h108);
        fork
            wb(1'b1, SCF_ADR_PUSH, 32'h108);
            pop(1'b1);
        join
        while (exp_q.size() > 0)
            pop(1'b1);
        flags(0);
        wb(1'b0, SCF_ADR_STATUS, 32'h0);
        chk(r, 32'h0000_0009, "drained");
        // consumer does not look at q when reading empty
        pop(1'b0);
        flags(0);
        // read and write in one cycle
        u_scf_dp_model.step(1'b1, 1'b0, 1'b0, 16'h1234);
        u_scf_dp_model.step(1'b1, 1'b1, 1'b0, 16'hfedc);
        idle();
        flags(1);
        chk(32'(q_o), 32'h1234, "rw q");
        exp_q.push_back(16'hfedc);
        pop(1'b1);
        // clear with words held and a write in the same cycle
        for (int i = 0; i < 3; i++)
            u_scf_dp_model.step(1'b1, 1'b0, 1'b0, 16'h0a0 + 16'(i));
        u_scf_dp_model.step(1'b1, 1'b0, 1'b1, 16'h0bad);
        idle();
        flags(0);
        // clear input ignored while software has it switched off
        wb(1'b1, SCF_ADR_CTRL, 32'h0);
        u_scf_dp_model.step(1'b1, 1'b0, 1'b0, 16'h0c01);
        u_scf_dp_model.step(1'b0, 1'b0, 1'b1, '0);
        idle();
        flags(1);
        // software flush; the flush bit reads back zero
        wb(1'b1, SCF_ADR_CTRL, 32'h6);
        wb(1'b0, SCF_ADR_CTRL, 32'h0);
        chk(r, 32'h2, "ctrl");
        idle();
        flags(0);
        // push without lane 0 is acked and dropped
        wb_sel_i <= 4'he;
        wb(1'b1, SCF_ADR_PUSH, 32'h0777);
        wb_sel_i <= 4'hf;
        idle();
        idle();
        flags(0);
        // show-ahead: head visible before the read that takes it
        wb(1'b1, SCF_ADR_CTRL, 32'h3);
        u_scf_dp_model.step(1'b1, 1'b0, 1'b0, 16'h5a5a);
        u_scf_dp_model.step(1'b1, 1'b0, 1'b0, 16'ha5a5);
        idle();
        idle();
        chk(32'(q_o), 32'h5a5a, "ahead");
        wb(1'b0, SCF_ADR_PUSH, 32'h0);
        chk(r, 32'h5a5a, "push read");
        pop(1'b0);
        chk(32'(q_o), 32'ha5a5, "ahead next");
        pop(1'b0);
        flags(0);
        u_scf_dp_model.step(1'b1, 1'b0, 1'b0, 16'h0e0e);
        idle();
        chk(32'(q_o), 32'h0e0e, "ahead write");
        // one-edge reset with a word held restores every reset value
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        idle();
        flags(0);
        chk(32'(q_o), 32'h0, "reset q");
        wb(1'b0, SCF_ADR_CTRL, 32'h0);
        chk(r, 32'(SCF_SCLR_RST) << SCF_CTRL_SCLR, "reset ctrl");
        print_verdict();
    end
endmodule
`default_nettype wire
